// *** core/twi_reg_slave.sv ***
// two-wire serial slave giving a bus master access to 16-bit registers
// assumes: LINK_CLK free running and much faster than SCLK; SDATA pulled up
// Function
// - slave only; the master drives the serial clock, never this block
// - pull data low only in own slots, otherwise release the line
// - device byte: seven address bits, direction in lsb; 0xba write, 0xbb read
// - acknowledge own device byte seen after a start
// - write: register address byte follows device byte and is acknowledged
// - registers hold 16 bits, written as two bytes
// - acknowledge every byte received during a write
// - register changes only after both bytes; half writes are dropped
// - register address steps by one after each 16-bit word
// - read data goes out byte by byte; master acknowledges each byte
// - master no-acknowledge ends a read; then wait for start or stop
// - both lines high is idle; only the master makes start and stop
// - data falling while clock high is a start; restarts the sequence
// - data rising while clock high is a stop; back to idle
// - one bit per clock pulse; data changes only while clock low
// - ninth pulse is the ack slot; transmitter releases, receiver pulls low
// - data left high in the ack slot is a no-acknowledge
`timescale 1ns/1ps
`default_nettype none

module twi_reg_slave #(
  parameter int AW = twi_slave_pkg::REG_AW,
  parameter int DW = twi_slave_pkg::REG_DW
) (
  input  wire logic MCLK,
  input  wire logic RESET_N,
  input  wire logic CE,
  input  wire logic LINK_CLK,
  input  wire logic SCLK,
  input  wire logic SDATA_IN,
  output logic      SDATA_OUT,
  output logic      SDATA_OE
);

  // ---- link domain: pin sampling ----
  logic                      ce_l;
  logic [1:0]                pins_s;
  logic                      scl_s;
  logic                      sda_s;
  logic                      scl_d_reg;
  logic                      sda_d_reg;
  logic                      ack_s;

  sync2_cell #(.W(1), .RST(1'b0)) u_ce_sync (
    .clk   (LINK_CLK),
    .rst_n (RESET_N),
    .ce    (1'b1),
    .d     (CE),
    .q     (ce_l)
  );

  // clock pin is only ever sampled, never driven
  sync2_cell #(.W(2), .RST(twi_slave_pkg::PIN_RST)) u_pin_sync (
    .clk   (LINK_CLK),
    .rst_n (RESET_N),
    .ce    (ce_l),
    .d     ({SCLK, SDATA_IN}),
    .q     (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (ce_l) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // ---- link domain: bus events ----
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ---- link domain: protocol state ----
  twi_slave_pkg::link_state_t state_reg;
  twi_slave_pkg::link_state_t state_next;
  logic [3:0]                 bcnt_reg;
  logic [3:0]                 bcnt_next;
  logic [7:0]                 sh_reg;
  logic [7:0]                 sh_next;
  logic                       oe_reg;
  logic                       oe_next;
  logic                       rw_reg;
  logic                       rw_next;
  logic [AW-1:0]              ptr_reg;
  logic [AW-1:0]              ptr_next;
  logic                       want_ptr_reg;
  logic                       want_ptr_next;
  logic                       hi_have_reg;
  logic                       hi_have_next;
  logic [7:0]                 hi_reg;
  logic [7:0]                 hi_next;
  logic                       tx_lo_reg;
  logic                       tx_lo_next;
  logic                       mack_reg;
  logic                       mack_next;
  logic                       rq_tog_reg;
  logic                       rq_tog_next;
  logic                       rq_we_reg;
  logic                       rq_we_next;
  logic [AW-1:0]              rq_addr_reg;
  logic [AW-1:0]              rq_addr_next;
  logic [DW-1:0]              rq_wdata_reg;
  logic [DW-1:0]              rq_wdata_next;
  logic [DW-1:0]              word_reg;
  logic                       ack_seen_reg;

  // ---- shared decodes ----
  logic          byte_full;
  logic          rx_phase;
  logic          adr_hit;
  logic [7:0]    tx_next_byte;
  logic [7:0]    tx_shift;
  logic [AW-1:0] ptr_inc;
  logic          ack_edge;

  assign byte_full    = (bcnt_reg == twi_slave_pkg::BYTE_BITS);
  assign rx_phase     = (state_reg == twi_slave_pkg::S_DEVADR) ||
                        (state_reg == twi_slave_pkg::S_RXBYTE);
  // 7-bit match; lsb is the direction
  assign adr_hit      = (sh_reg[7:1] == twi_slave_pkg::DEV_ADDR_WR[7:1]);
  // upper byte first, then lower
  assign tx_next_byte = tx_lo_reg ? word_reg[15:8] : word_reg[7:0];
  assign tx_shift     = {sh_reg[6:0], 1'b0};
  assign ptr_inc      = ptr_reg + 1'b1;
  assign ack_edge     = ack_s ^ ack_seen_reg;

  always_comb begin
    state_next    = state_reg;
    bcnt_next     = bcnt_reg;
    sh_next       = sh_reg;
    oe_next       = oe_reg;
    rw_next       = rw_reg;
    ptr_next      = ptr_reg;
    want_ptr_next = want_ptr_reg;
    hi_have_next  = hi_have_reg;
    hi_next       = hi_reg;
    tx_lo_next    = tx_lo_reg;
    mack_next     = mack_reg;
    rq_tog_next   = rq_tog_reg;
    rq_we_next    = rq_we_reg;
    rq_addr_next  = rq_addr_reg;
    rq_wdata_next = rq_wdata_reg;
    if (stop_det) begin
      // release, drop any half word
      state_next   = twi_slave_pkg::S_IDLE;
      oe_next      = 1'b0;
      hi_have_next = 1'b0;
    end else if (start_det) begin
      // start or repeated start aborts whatever was running
      state_next   = twi_slave_pkg::S_DEVADR;
      bcnt_next    = twi_slave_pkg::BCNT_RST;
      oe_next      = 1'b0;
      hi_have_next = 1'b0;
    end else if (scl_rise && rx_phase && !byte_full) begin
      // sample while clock high, msb first
      sh_next   = {sh_reg[6:0], sda_s};
      bcnt_next = bcnt_reg + 1'b1;
    end else if (scl_rise && state_reg == twi_slave_pkg::S_TXBYTE) begin
      bcnt_next = bcnt_reg + 1'b1;
    end else if (scl_rise && state_reg == twi_slave_pkg::S_TXACK) begin
      // low is ack, high is no-acknowledge
      mack_next = ~sda_s;
    end else if (scl_fall) begin
      case (state_reg)
        twi_slave_pkg::S_DEVADR: begin
          if (byte_full && adr_hit) begin
            oe_next       = 1'b1;
            rw_next       = sh_reg[0];
            want_ptr_next = ~sh_reg[0];
            state_next    = twi_slave_pkg::S_DEVACK;
          end else if (byte_full) begin
            state_next = twi_slave_pkg::S_WAIT;
          end
        end
        twi_slave_pkg::S_DEVACK: begin
          bcnt_next = twi_slave_pkg::BCNT_RST;
          if (rw_reg) begin
            // pointer kept from the earlier write phase
            sh_next    = word_reg[15:8];
            oe_next    = ~word_reg[15];
            tx_lo_next = 1'b0;
            state_next = twi_slave_pkg::S_TXBYTE;
          end else begin
            oe_next    = 1'b0;
            state_next = twi_slave_pkg::S_RXBYTE;
          end
        end
        twi_slave_pkg::S_RXBYTE: begin
          if (byte_full) begin
            oe_next    = 1'b1;
            state_next = twi_slave_pkg::S_RXACK;
            if (want_ptr_reg) begin
              // first byte is the register pointer; prefetch it
              ptr_next      = sh_reg;
              want_ptr_next = 1'b0;
              rq_tog_next   = ~rq_tog_reg;
              rq_we_next    = 1'b0;
              rq_addr_next  = sh_reg;
            end else if (!hi_have_reg) begin
              hi_next      = sh_reg;
              hi_have_next = 1'b1;
            end else begin
              // whole word in hand: commit, then step
              rq_tog_next   = ~rq_tog_reg;
              rq_we_next    = 1'b1;
              rq_addr_next  = ptr_reg;
              rq_wdata_next = {hi_reg, sh_reg};
              ptr_next      = ptr_inc;
              hi_have_next  = 1'b0;
            end
          end
        end
        twi_slave_pkg::S_RXACK: begin
          oe_next    = 1'b0;
          bcnt_next  = twi_slave_pkg::BCNT_RST;
          state_next = twi_slave_pkg::S_RXBYTE;
        end
        twi_slave_pkg::S_TXBYTE: begin
          if (byte_full) begin
            oe_next    = 1'b0;
            state_next = twi_slave_pkg::S_TXACK;
            if (tx_lo_reg) begin
              // fetch next word during the ack slot
              ptr_next     = ptr_inc;
              rq_tog_next  = ~rq_tog_reg;
              rq_we_next   = 1'b0;
              rq_addr_next = ptr_inc;
            end
          end else begin
            // change data only while the clock is low
            sh_next = tx_shift;
            oe_next = ~sh_reg[6];
          end
        end
        twi_slave_pkg::S_TXACK: begin
          bcnt_next = twi_slave_pkg::BCNT_RST;
          if (mack_reg) begin
            sh_next    = tx_next_byte;
            oe_next    = ~tx_next_byte[7];
            tx_lo_next = ~tx_lo_reg;
            state_next = twi_slave_pkg::S_TXBYTE;
          end else begin
            // stop sending; only start or stop leaves here
            oe_next    = 1'b0;
            state_next = twi_slave_pkg::S_WAIT;
          end
        end
        twi_slave_pkg::S_IDLE: begin
          oe_next = 1'b0;
        end
        twi_slave_pkg::S_WAIT: begin
          oe_next = 1'b0;
        end
        default: begin
          oe_next    = 1'b0;
          state_next = twi_slave_pkg::S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg    <= twi_slave_pkg::S_IDLE;
      bcnt_reg     <= twi_slave_pkg::BCNT_RST;
      sh_reg       <= twi_slave_pkg::BYTE_RST;
      oe_reg       <= 1'b0;
      rw_reg       <= 1'b0;
      hi_reg       <= twi_slave_pkg::BYTE_RST;
      tx_lo_reg    <= 1'b0;
      mack_reg     <= 1'b0;
    end else if (ce_l) begin
      state_reg    <= state_next;
      bcnt_reg     <= bcnt_next;
      sh_reg       <= sh_next;
      oe_reg       <= oe_next;
      rw_reg       <= rw_next;
      hi_reg       <= hi_next;
      tx_lo_reg    <= tx_lo_next;
      mack_reg     <= mack_next;
    end
  end

  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ptr_reg      <= twi_slave_pkg::PTR_RST;
      want_ptr_reg <= 1'b0;
      hi_have_reg  <= 1'b0;
    end else if (ce_l) begin
      ptr_reg      <= ptr_next;
      want_ptr_reg <= want_ptr_next;
      hi_have_reg  <= hi_have_next;
    end
  end

  // request words stay still until the next toggle, so MCLK may read them
  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rq_tog_reg   <= 1'b0;
      rq_we_reg    <= 1'b0;
      rq_addr_reg  <= twi_slave_pkg::PTR_RST;
      rq_wdata_reg <= twi_slave_pkg::WORD_RST;
    end else if (ce_l) begin
      rq_tog_reg   <= rq_tog_next;
      rq_we_reg    <= rq_we_next;
      rq_addr_reg  <= rq_addr_next;
      rq_wdata_reg <= rq_wdata_next;
    end
  end

  // ---- MCLK domain: register access side ----
  logic rq_s;
  logic rq_seen_reg;
  logic rq_edge;
  logic done_reg;
  logic ack_tog_reg;

  reg_port_if #(.AW(AW), .DW(DW)) rp ();

  sync2_cell #(.W(1), .RST(1'b0)) u_req_sync (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .ce    (CE),
    .d     (rq_tog_reg),
    .q     (rq_s)
  );

  assign rq_edge  = rq_s ^ rq_seen_reg;
  assign rp.wr_en = rq_edge & rq_we_reg;
  assign rp.rd_en = rq_edge & ~rq_we_reg;
  assign rp.addr  = rq_addr_reg;
  assign rp.wdata = rq_wdata_reg;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rq_seen_reg <= 1'b0;
      done_reg    <= 1'b0;
      ack_tog_reg <= 1'b0;
    end else if (CE) begin
      rq_seen_reg <= rq_s;
      done_reg    <= rq_edge;
      ack_tog_reg <= ack_tog_reg ^ done_reg;
    end
  end

  reg_store_mem #(.AW(AW), .DW(DW)) u_store (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .ce    (CE),
    .port  (rp.mem)
  );

  // ---- back to the link: read data is stable once the ack toggles ----
  sync2_cell #(.W(1), .RST(1'b0)) u_ack_sync (
    .clk   (LINK_CLK),
    .rst_n (RESET_N),
    .ce    (ce_l),
    .d     (ack_tog_reg),
    .q     (ack_s)
  );

  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_seen_reg <= 1'b0;
      word_reg     <= twi_slave_pkg::WORD_RST;
    end else if (ce_l) begin
      ack_seen_reg <= ack_s;
      if (ack_edge && !rq_we_reg) begin
        word_reg <= rp.rdata;
      end
    end
  end

  // open drain: only ever pull low
  assign SDATA_OUT = 1'b0;
  assign SDATA_OE  = oe_reg;

endmodule // twi_reg_slave

`default_nettype wire

// *** include/twi_slave_pkg.sv ***
// package: constants and types for the two-wire register access slave
// assumes: referenced by scoped name only, never imported
package twi_slave_pkg;

  localparam logic [7:0]  DEV_ADDR_WR = 8'hba;
  localparam logic [7:0]  DEV_ADDR_RD = 8'hbb;
  localparam int          REG_AW      = 8;
  localparam int          REG_DW      = 16;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [3:0]  BCNT_RST    = 4'h0;
  localparam logic [7:0]  PTR_RST     = 8'h00;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [15:0] WORD_RST    = 16'h0000;
  localparam logic [1:0]  PIN_RST     = 2'h3;

  // gray codes along address, ack, byte, ack
  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_DEVADR = 3'h1,
    S_DEVACK = 3'h3,
    S_RXBYTE = 3'h2,
    S_RXACK  = 3'h6,
    S_TXBYTE = 3'h7,
    S_TXACK  = 3'h5,
    S_WAIT   = 3'h4
  } link_state_t;

endpackage

// *** include/reg_port_if.sv ***
// interface: word access port between the slave core and its register store
// assumes: store side on MCLK; the core drives addr and wdata from LINK_CLK registers and reads rdata on LINK_CLK
`timescale 1ns/1ps
`default_nettype none

interface reg_port_if #(
  parameter int AW = 8,
  parameter int DW = 16
);
  logic          wr_en;
  logic          rd_en;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport ctrl (
    output wr_en,
    output rd_en,
    output addr,
    output wdata,
    input  rdata
  );

  modport mem (
    input  wr_en,
    input  rd_en,
    input  addr,
    input  wdata,
    output rdata
  );
endinterface

`default_nettype wire

// *** core/sync2_cell.sv ***
// two flip-flop synchroniser for levels and toggles
// assumes: d is asynchronous to clk; only q is read by other logic
`timescale 1ns/1ps
`default_nettype none

module sync2_cell #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST;
      q        <= RST;
    end else if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // sync2_cell

`default_nettype wire

// *** core/reg_store_mem.sv ***
// register store: 16-bit words, write port and registered read data
// assumes: single clock, strobes last one cycle
`timescale 1ns/1ps
`default_nettype none

module reg_store_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  reg_port_if.mem   port
);
  logic [DW-1:0] cells [2**AW];
  logic [DW-1:0] rdata_reg;

  // no reset on the array: cells never written read as unknown
  always_ff @(posedge clk) begin
    if (ce && port.wr_en) begin
      cells[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (ce && port.rd_en) begin
      rdata_reg <= cells[port.addr];
    end
  end

  assign port.rdata = rdata_reg;
endmodule // reg_store_mem

`default_nettype wire

// *** dv/twi_reg_slave_chk.sv ***
// checker: link-side properties of the two-wire slave, pins only
// assumes: raw pins sampled on LINK_CLK; bound into every twi_reg_slave
`timescale 1ns/1ps
`default_nettype none
module twi_reg_slave_chk (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic LINK_CLK,
  input wire logic SCLK,
  input wire logic SDATA_IN,
  input wire logic SDATA_OUT,
  input wire logic SDATA_OE
);
  logic       scl_reg, sda_reg, first_reg, rd_reg, wr_reg, idle_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [5:0] lo_reg;
  wire        rise_w  = SCLK & ~scl_reg;
  wire        start_w = SCLK & scl_reg & sda_reg & ~SDATA_IN;
  wire        stop_w  = SCLK & scl_reg & ~sda_reg & SDATA_IN;
  wire        slot_w  = rise_w & (bit_reg == 4'h8);
  wire        own_w   = (sh_reg[7:1] == 7'h5d);

  // raw pins, so every bound below allows for the core's two sync flops
  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_reg   <= 1'b1;
      sda_reg   <= 1'b1;
      first_reg <= 1'b0;
      rd_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      idle_reg  <= 1'b0;
      bit_reg   <= 4'h0;
      sh_reg    <= 8'h00;
      lo_reg    <= 6'h00;
    end else begin
      scl_reg <= SCLK;
      sda_reg <= SDATA_IN;
      lo_reg  <= SCLK ? 6'h00 : lo_reg + {5'h00, lo_reg != 6'h3f};
      if (start_w || stop_w) begin
        bit_reg   <= 4'h0;
        first_reg <= start_w;
        rd_reg    <= 1'b0;
        wr_reg    <= 1'b0;
        idle_reg  <= 1'b0;
      end else if (rise_w) begin
        bit_reg <= slot_w ? 4'h0 : bit_reg + 4'h1;
        sh_reg  <= slot_w ? sh_reg : {sh_reg[6:0], SDATA_IN};
        if (slot_w && first_reg) begin
          first_reg <= 1'b0;
          rd_reg    <= own_w & sh_reg[0];
          wr_reg    <= own_w & ~sh_reg[0];
          idle_reg  <= ~own_w;
        end
        if (slot_w && rd_reg && !first_reg && SDATA_IN)
          idle_reg <= 1'b1;
      end
    end
  end

  sequence s_released;
    !SDATA_OE [*8];
  endsequence
  default clocking cb @(posedge LINK_CLK); endclocking
  default disable iff (!RESET_N);

  a_out_low: assert property (SDATA_OUT == 1'b0)
    else $error("data output not held low");
  a_addr_ack: assert property (slot_w && first_reg |-> SDATA_OE == own_w)
    else $error("device byte answered wrongly");
  a_wr_ack: assert property (slot_w && wr_reg && !first_reg |-> SDATA_OE)
    else $error("write byte not acknowledged");
  a_rd_slot: assert property (slot_w && rd_reg && !first_reg |-> !SDATA_OE)
    else $error("data held in master ack slot");
  a_idle_off: assert property (idle_reg |-> !SDATA_OE)
    else $error("data pulled after refusal or nack");
  a_high_stable: assert property (SCLK && $past(SCLK, 4) |-> $stable(SDATA_OE))
    else $error("data moved while clock high");
  a_oe_timing: assert property ($changed(SDATA_OE) |-> !SCLK && lo_reg inside {[1:7]})
    else $error("data enable moved off its slot");
  a_start_off: assert property (start_w |-> ##4 s_released)
    else $error("data pulled after start");
  a_stop_off: assert property (stop_w |-> ##4 s_released)
    else $error("data pulled after stop");
endmodule // twi_reg_slave_chk

bind twi_reg_slave twi_reg_slave_chk twi_reg_slave_chk_i (
  .MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .LINK_CLK(LINK_CLK), .SCLK(SCLK),
  .SDATA_IN(SDATA_IN), .SDATA_OUT(SDATA_OUT), .SDATA_OE(SDATA_OE)
);
`default_nettype wire

// *** dv/twi_master_model.sv ***
// partner: two-wire bus master, drives the clock and pulls the data wire
// assumes: sda is the resolved wire with pull-up; tasks called from tb
`timescale 1ns/1ps
`default_nettype none
module twi_master_model #(
  parameter int HALF = 25
) (
  input  wire logic       clk,
  input  wire logic       sda,
  output var  logic       scl,
  output var  logic       pull,
  output var  logic       res_stb,
  output var  logic       res_kind,
  output var  logic [7:0] res_val
);
  initial begin
    scl      = 1'b1;
    pull     = 1'b0;
    res_stb  = 1'b0;
    res_kind = 1'b0;
    res_val  = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic report(input logic k, input logic [7:0] v);
    res_kind = k;
    res_val  = v;
    res_stb  = 1'b1;
    tick(1);
    res_stb  = 1'b0;
  endtask
  // data moves only in the low half, sampled mid high half
  task automatic bit_io(input logic b, output logic r);
    tick(HALF / 2);
    pull = ~b;
    tick(HALF - HALF / 2);
    scl = 1'b1;
    tick(HALF / 2);
    r = sda;
    tick(HALF - HALF / 2);
    scl = 1'b0;
  endtask
  task automatic start();
    pull = 1'b0;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF);
    pull = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask
  task automatic stop();
    pull = 1'b1;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF);
    pull = 1'b0;
    tick(HALF);
  endtask
  task automatic send(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    report(1'b0, {7'h00, r});
  endtask
  task automatic recv(input logic ack);
    logic [7:0] v;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(~ack, r);
    report(1'b1, v);
  endtask
endmodule // twi_master_model
`default_nettype wire

// *** dv/tb.sv ***
// testbench: self-checking run of the two-wire register slave
// assumes: partner model plays the bus master; checker bound to the core
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic       kind;
    logic [7:0] val;
  } note_t;
  logic        mclk, link_clk, reset_n, sda_oe, sda_out, ce;
  logic        scl, pull, res_stb, res_kind;
  logic [7:0]  res_val, a;
  logic [15:0] lf, w1, w2, w3;
  wire         sda_w = ~(sda_oe | pull);
  note_t       notes[$];
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  twi_reg_slave twi_reg_slave_i (
    .MCLK(mclk), .RESET_N(reset_n), .CE(ce), .LINK_CLK(link_clk), .SCLK(scl),
    .SDATA_IN(sda_w), .SDATA_OUT(sda_out), .SDATA_OE(sda_oe)
  );
  twi_master_model m_i (
    .clk(mclk), .sda(sda_w), .scl(scl), .pull(pull), .res_stb(res_stb),
    .res_kind(res_kind), .res_val(res_val)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp_ack(input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD ack exp %h got %h", e, g);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD read byte exp %h got %h", e, g);
    end
  endtask
  task automatic end_sim();
    if (notes.size() != 0)
      fails++;
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic put(input logic [7:0] b, input logic nack);
    notes.push_back('{1'b0, {7'h00, nack}});
    m_i.send(b);
  endtask
  task automatic get(input logic [7:0] e, input logic ack);
    notes.push_back('{1'b1, e});
    m_i.recv(ack);
  endtask
  task automatic set_ptr(input logic [7:0] p);
    m_i.start();
    put(twi_slave_pkg::DEV_ADDR_WR, 1'b0);
    put(p, 1'b0);
  endtask
  task automatic wr2(input logic [7:0] p, input logic [15:0] x, input logic [15:0] y);
    set_ptr(p);
    put(x[15:8], 1'b0);
    put(x[7:0], 1'b0);
    put(y[15:8], 1'b0);
    put(y[7:0], 1'b0);
    m_i.stop();
  endtask
  task automatic rd2(input logic [7:0] p, input logic [15:0] x, input logic [15:0] y);
    set_ptr(p);
    m_i.start();
    put(twi_slave_pkg::DEV_ADDR_RD, 1'b0);
    get(x[15:8], 1'b1);
    get(x[7:0], 1'b1);
    get(y[15:8], 1'b1);
    get(y[7:0], 1'b0);
    m_i.stop();
  endtask

  always @(posedge mclk) begin : watch
    note_t n;
    if (res_stb === 1'b1) begin
      n = (notes.size() > 0) ? notes.pop_front() : '{1'b1, 8'hxx};
      if (n.kind)
        cmp_byte(n.val, res_val);
      else
        cmp_ack(n.val[0], res_val[0]);
    end
  end
  // generous ceiling: the run needs about 26000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    lf = 16'h0025;
    repeat (20) @(posedge mclk);
    #2;
    reset_n = 1'b1;
    repeat (10) @(posedge mclk);
    #2;
    lf = lfsr(lf);
    w1 = lf;
    wr2(8'h09, 16'h0284, w1);
    rd2(8'h09, 16'h0284, w1);
    // half words ended by stop, then by repeated start, are dropped
    set_ptr(8'h09);
    put(w1[7:0], 1'b0);
    m_i.stop();
    set_ptr(8'h0a);
    put(8'h5a, 1'b0);
    rd2(8'h09, 16'h0284, w1);
    lf = lfsr(lf);
    w2 = lf;
    lf = lfsr(lf);
    w3 = lf;
    wr2(8'hff, w2, w3);
    rd2(8'hff, w2, w3);
    // freeze only while the bus is idle; resync before the next start
    ce = 1'b0;
    repeat (20) @(posedge mclk);
    #2;
    ce = 1'b1;
    repeat (6) @(posedge mclk);
    #2;
    rd2(8'hff, w2, w3);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      a = lf[7:0];
      if (a[7:1] == twi_slave_pkg::DEV_ADDR_WR[7:1])
        a = a ^ 8'h80;
      m_i.start();
      put(a, 1'b1);
      put(8'h00, 1'b1);
      m_i.stop();
    end
    end_sim();
  end
endmodule // tb
`default_nettype wire
